// [logic/ctxm_consts.vh]
// Constants for the transmit/receive mode configuration block.
// Assumes inclusion by bare name from the design files only.
`ifndef CTXM_CONSTS_VH
`define CTXM_CONSTS_VH

// Register addresses on the host register port
`define CTXM_ADDR_W 6
`define CTXM_ADDR_TX_MODE 6'h12
`define CTXM_ADDR_RX_MODE 6'h13

// Reset values of both mode registers
`define CTXM_TX_MODE_RST 8'h00
`define CTXM_RX_MODE_RST 8'h00

// Writable bit masks; reserved bits read zero
`define CTXM_TX_MODE_WMASK 8'hf8
`define CTXM_RX_MODE_WMASK 8'hfc

// Field positions; CRC enable and speed shared by both mode registers, bit 3 per register, bit 2 receive only
`define CTXM_CRC_EN_BIT 7
`define CTXM_SPD_HI 6
`define CTXM_SPD_LO 4
`define CTXM_TX_INV_BIT 3
`define CTXM_RX_RUNT_BIT 3
`define CTXM_RX_MULTI_BIT 2

// Bit rate codes
`define CTXM_SPD_106 3'h0
`define CTXM_SPD_212 3'h1
`define CTXM_SPD_424 3'h2
`define CTXM_SPD_848 3'h3

// Error status byte: position of the CRC indication
`define CTXM_ERR_CRC_BIT 2

// Shortest valid received stream in bits
`define CTXM_RUNT_BITS 3'h4

// Bit index inside a byte
`define CTXM_LAST_BIT 3'h7
`define CTXM_BIT_ZERO 3'h0

// CRC seed code chosen automatically during RF traffic
`define CTXM_SEED_AUTO 2'h1

// Device revisions
`define CTXM_REV_1 1
`define CTXM_REV_2 2

`endif

// [logic/ctxm_fifo.v]
// Receive data FIFO, flip-flop storage, valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module ctxm_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0] count_ff;
  wire push;
  wire pop;

  // Full and empty straight from the occupancy count
  assign in_ready = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // One storage word per entry
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_entry
      localparam integer ENTRY = gi;
      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          mem_ff[gi] <= {WIDTH{1'b0}};
        end else if (push && wr_ptr_ff == ENTRY[AW-1:0]) begin
          mem_ff[gi] <= in_data;
        end
      end
    end
  endgenerate

  // Pointers wrap; depth assumed a power of two
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // ctxm_fifo

`default_nettype wire

// [logic/ctxm_mode_cfg.v]
// Transmit and receive mode registers with the framing they steer.
// Assumes a synchronous host register port, a bit-level decoder that
// honours rx_hold_ff, and command strobes from the command logic.
`timescale 1ns/1ps
`default_nettype none
`include "ctxm_consts.vh"

module ctxm_mode_cfg #(
  parameter REVISION = 2,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire clk_sys,
  input wire arst_n,
  input wire [5:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_ff,
  input wire cmd_receive_start,
  input wire cmd_other,
  input wire rf_busy,
  input wire [1:0] crc_seed_select,
  input wire tx_data_bit,
  output reg tx_mod_ff,
  output reg tx_crc_append_ff,
  output reg [2:0] tx_rate_ff,
  output reg rx_crc_check_ff,
  output reg [2:0] rx_rate_ff,
  output reg [1:0] crc_seed_ff,
  input wire rx_bit_valid,
  input wire rx_bit,
  input wire rx_frame_end,
  output reg rx_hold_ff,
  output reg rx_active_ff,
  input wire [7:0] error_status_register,
  input wire crc_correct_flag,
  output reg [7:0] rx_data_ff,
  output reg rx_data_valid_ff,
  input wire rx_data_ready
);

  // Receiver states, one-hot
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_WAIT = 4'b0010;
  localparam [3:0] S_RECV = 4'b0100;
  localparam [3:0] S_FLUSH = 4'b1000;

  reg [7:0] tx_mode_ff;
  reg [7:0] rx_mode_ff;
  reg [7:0] nxt_tx_mode;
  reg [7:0] nxt_rx_mode;
  reg [3:0] state_ff;
  reg [3:0] nxt_state;
  reg [7:0] byte_ff;
  reg [7:0] nxt_byte;
  reg [2:0] bit_cnt_ff;
  reg [2:0] nxt_bit_cnt;
  reg any_byte_ff;
  reg nxt_any_byte;
  reg need_part_ff;
  reg nxt_need_part;
  reg need_err_ff;
  reg nxt_need_err;
  reg pend_valid_ff;
  reg nxt_pend_valid;
  reg [7:0] pend_data_ff;
  reg [7:0] nxt_pend_data;
  reg [7:0] err_byte;
  reg any_frame_seen_ff;
  wire [2:0] wr_spd;
  wire tx_sel;
  wire rx_sel;
  wire multi_eff;
  wire runt;
  wire pend_fire;
  wire pend_free;
  wire bit_take;
  wire fifo_in_ready;
  wire [7:0] fifo_out_data;
  wire fifo_out_valid;
  wire fifo_out_ready;

  assign tx_sel = (reg_addr == `CTXM_ADDR_TX_MODE);
  assign rx_sel = (reg_addr == `CTXM_ADDR_RX_MODE);
  assign wr_spd = reg_wdata[`CTXM_SPD_HI:`CTXM_SPD_LO];

  // Multi-frame only counts above the base rate
  assign multi_eff = rx_mode_ff[`CTXM_RX_MULTI_BIT] &
    (rx_mode_ff[`CTXM_SPD_HI:`CTXM_SPD_LO] != `CTXM_SPD_106);

  // Under four bits and no whole byte seen
  assign runt = !any_byte_ff && (bit_cnt_ff < `CTXM_RUNT_BITS);

  assign pend_fire = pend_valid_ff & fifo_in_ready;
  assign pend_free = !pend_valid_ff | pend_fire;
  assign bit_take = rx_bit_valid & !rx_hold_ff &
    ((state_ff == S_WAIT) | (state_ff == S_RECV));

  // Mode register writes. A reserved speed code keeps the old speed so
  // the encoder never sees an undefined rate; the CRC enable cannot
  // drop to zero unless the resulting speed is the base rate.
  always @* begin
    nxt_tx_mode = tx_mode_ff;
    nxt_rx_mode = rx_mode_ff;
    if (reg_wr && tx_sel) begin
      nxt_tx_mode = reg_wdata & `CTXM_TX_MODE_WMASK;
      if (wr_spd > `CTXM_SPD_848) begin
        nxt_tx_mode[`CTXM_SPD_HI:`CTXM_SPD_LO] =
          tx_mode_ff[`CTXM_SPD_HI:`CTXM_SPD_LO];
      end
      if (nxt_tx_mode[`CTXM_SPD_HI:`CTXM_SPD_LO] != `CTXM_SPD_106) begin
        nxt_tx_mode[`CTXM_CRC_EN_BIT] = 1'b1;
      end
    end
    if (reg_wr && rx_sel) begin
      nxt_rx_mode = reg_wdata & `CTXM_RX_MODE_WMASK;
      if (wr_spd > `CTXM_SPD_848) begin
        nxt_rx_mode[`CTXM_SPD_HI:`CTXM_SPD_LO] =
          rx_mode_ff[`CTXM_SPD_HI:`CTXM_SPD_LO];
      end
      if (nxt_rx_mode[`CTXM_SPD_HI:`CTXM_SPD_LO] != `CTXM_SPD_106) begin
        nxt_rx_mode[`CTXM_CRC_EN_BIT] = 1'b1;
      end
    end
  end

  // Error byte: CRC slot carries correct or fault sense by revision
  always @* begin
    err_byte = error_status_register;
    if (REVISION == `CTXM_REV_2) begin
      err_byte[`CTXM_ERR_CRC_BIT] = crc_correct_flag;
    end
  end

  // Receiver sequencing and byte assembly, LSB first
  always @* begin
    nxt_state = state_ff;
    nxt_byte = byte_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_any_byte = any_byte_ff;
    nxt_need_part = need_part_ff;
    nxt_need_err = need_err_ff;
    nxt_pend_valid = pend_valid_ff & !pend_fire;
    nxt_pend_data = pend_data_ff;
    case (state_ff)
      S_IDLE: begin
        if (cmd_receive_start) begin
          nxt_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (cmd_other) begin
          nxt_state = S_IDLE;
        end else if (bit_take) begin
          nxt_byte[`CTXM_BIT_ZERO] = rx_bit;
          nxt_bit_cnt = bit_cnt_ff + 3'h1;
          nxt_state = S_RECV;
        end else if (rx_frame_end) begin
          // Empty stream is a runt too
          if (rx_mode_ff[`CTXM_RX_RUNT_BIT]) begin
            nxt_state = S_WAIT;
          end else begin
            nxt_need_err = multi_eff;
            nxt_state = S_FLUSH;
          end
        end
      end
      S_RECV: begin
        if (cmd_other) begin
          // Abort drops the partial byte
          nxt_state = S_IDLE;
          nxt_bit_cnt = `CTXM_BIT_ZERO;
          nxt_any_byte = 1'b0;
          nxt_byte = 8'h00;
        end else if (bit_take) begin
          nxt_byte[bit_cnt_ff] = rx_bit;
          nxt_bit_cnt = bit_cnt_ff + 3'h1;
          if (bit_cnt_ff == `CTXM_LAST_BIT) begin
            // Hold blocks every bit while pend is full, so pend is free here
            nxt_pend_valid = 1'b1;
            nxt_pend_data = nxt_byte;
            nxt_any_byte = 1'b1;
            nxt_byte = 8'h00;
          end
        end else if (rx_frame_end) begin
          if (runt && rx_mode_ff[`CTXM_RX_RUNT_BIT]) begin
            // Discard and keep listening
            nxt_state = S_WAIT;
            nxt_bit_cnt = `CTXM_BIT_ZERO;
            nxt_byte = 8'h00;
          end else begin
            nxt_need_part = (bit_cnt_ff != `CTXM_BIT_ZERO);
            nxt_need_err = multi_eff;
            nxt_state = S_FLUSH;
          end
        end
      end
      S_FLUSH: begin
        if (cmd_other) begin
          nxt_state = S_IDLE;
          nxt_need_part = 1'b0;
          nxt_need_err = 1'b0;
        end else if (pend_free) begin
          if (need_part_ff) begin
            nxt_pend_valid = 1'b1;
            nxt_pend_data = byte_ff;
            nxt_need_part = 1'b0;
          end else if (need_err_ff) begin
            nxt_pend_valid = 1'b1;
            nxt_pend_data = err_byte;
            nxt_need_err = 1'b0;
          end else if (multi_eff) begin
            nxt_state = S_WAIT;
          end else begin
            nxt_state = S_IDLE;
          end
          if (!need_part_ff) begin
            nxt_bit_cnt = `CTXM_BIT_ZERO;
            nxt_any_byte = 1'b0;
            nxt_byte = 8'h00;
          end
        end
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
    // Clearing the multi bit between frames ends reception
    if (state_ff == S_WAIT && !cmd_other && !bit_take &&
        !rx_frame_end && !multi_eff && any_frame_seen_ff) begin
      nxt_state = S_IDLE;
    end
  end

  // Remembers that a frame already finished in this reception

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      any_frame_seen_ff <= 1'b0;
    end else if (state_ff == S_IDLE) begin
      any_frame_seen_ff <= 1'b0;
    end else if (state_ff == S_FLUSH) begin
      any_frame_seen_ff <= 1'b1;
    end
  end

  // Mode registers and receiver state
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_mode_ff <= `CTXM_TX_MODE_RST;
      rx_mode_ff <= `CTXM_RX_MODE_RST;
      state_ff <= S_IDLE;
      byte_ff <= 8'h00;
      bit_cnt_ff <= `CTXM_BIT_ZERO;
      any_byte_ff <= 1'b0;
      need_part_ff <= 1'b0;
      need_err_ff <= 1'b0;
      pend_valid_ff <= 1'b0;
      pend_data_ff <= 8'h00;
    end else begin
      tx_mode_ff <= nxt_tx_mode;
      rx_mode_ff <= nxt_rx_mode;
      state_ff <= nxt_state;
      byte_ff <= nxt_byte;
      bit_cnt_ff <= nxt_bit_cnt;
      any_byte_ff <= nxt_any_byte;
      need_part_ff <= nxt_need_part;
      need_err_ff <= nxt_need_err;
      pend_valid_ff <= nxt_pend_valid;
      pend_data_ff <= nxt_pend_data;
    end
  end

  // Registered outputs toward the encoder, decoder and CRC unit
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_ff <= 8'h00;
      tx_mod_ff <= 1'b0;
      tx_crc_append_ff <= 1'b0;
      tx_rate_ff <= `CTXM_SPD_106;
      rx_crc_check_ff <= 1'b0;
      rx_rate_ff <= `CTXM_SPD_106;
      crc_seed_ff <= 2'h0;
      rx_hold_ff <= 1'b0;
      rx_active_ff <= 1'b0;
    end else begin
      // Unmapped addresses read zero
      if (reg_rd) begin
        if (tx_sel) begin
          reg_rdata_ff <= tx_mode_ff;
        end else if (rx_sel) begin
          reg_rdata_ff <= rx_mode_ff;
        end else begin
          reg_rdata_ff <= 8'h00;
        end
      end
      tx_mod_ff <= tx_data_bit ^ tx_mode_ff[`CTXM_TX_INV_BIT];
      tx_crc_append_ff <= tx_mode_ff[`CTXM_CRC_EN_BIT];
      tx_rate_ff <= tx_mode_ff[`CTXM_SPD_HI:`CTXM_SPD_LO];
      rx_crc_check_ff <= rx_mode_ff[`CTXM_CRC_EN_BIT];
      rx_rate_ff <= rx_mode_ff[`CTXM_SPD_HI:`CTXM_SPD_LO];
      // Software seed only outside RF traffic
      if (rf_busy) begin
        crc_seed_ff <= `CTXM_SEED_AUTO;
      end else begin
        crc_seed_ff <= crc_seed_select;
      end
      // Stall the decoder while a byte waits for FIFO room
      rx_hold_ff <= nxt_pend_valid;
      rx_active_ff <= (nxt_state != S_IDLE);
    end
  end

  // Receive FIFO; its full flag stalls the decoder through rx_hold_ff
  ctxm_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_data(pend_data_ff),
    .in_valid(pend_valid_ff),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready)
  );

  // Output register stage keeps the top outputs on flip-flops
  assign fifo_out_ready = !rx_data_valid_ff | rx_data_ready;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rx_data_ff <= 8'h00;
      rx_data_valid_ff <= 1'b0;
    end else if (fifo_out_ready) begin
      rx_data_valid_ff <= fifo_out_valid;
      if (fifo_out_valid) begin
        rx_data_ff <= fifo_out_data;
      end
    end
  end

endmodule // ctxm_mode_cfg

`default_nettype wire

// [sim/ctxm_card_model.sv]
// Card-side model: feeds received bits into the mode block.
// Assumes the bench calls send_frame; honours the hold output.
`timescale 1ns/1ps
`default_nettype none
module ctxm_card_model (
  input wire logic clk_sys,
  input wire logic rx_hold_ff,
  output var logic rx_bit_valid,
  output var logic rx_bit,
  output var logic rx_frame_end
);
  initial begin
    rx_bit_valid = 1'b0;
    rx_bit = 1'b0;
    rx_frame_end = 1'b0;
  end

  // LSB first; a bit stands until taken with hold low
  task automatic send_frame(input logic [95:0] d, input int n);
    for (int i = 0; i < n; i++) begin
      rx_bit <= d[i];
      rx_bit_valid <= 1'b1;
      do @(posedge clk_sys); while (rx_hold_ff);
    end
    // Released line flips, so no stale bit looks valid
    rx_bit_valid <= 1'b0;
    rx_bit <= ~rx_bit;
    @(posedge clk_sys);
    rx_frame_end <= 1'b1;
    @(posedge clk_sys);
    rx_frame_end <= 1'b0;
  endtask
endmodule // ctxm_card_model
`default_nettype wire

// [sim/ctxm_mode_cfg_properties.sv]
// Port checks for the mode block.
// Assumes binding into ctxm_mode_cfg; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ctxm_mode_cfg_properties (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_ff,
  input wire logic cmd_other,
  input wire logic rf_busy,
  input wire logic [1:0] crc_seed_select,
  input wire logic tx_data_bit,
  input wire logic tx_mod_ff,
  input wire logic tx_crc_append_ff,
  input wire logic [2:0] tx_rate_ff,
  input wire logic rx_crc_check_ff,
  input wire logic [2:0] rx_rate_ff,
  input wire logic [1:0] crc_seed_ff,
  input wire logic rx_active_ff,
  input wire logic rx_frame_end,
  input wire logic rx_data_valid_ff,
  input wire logic rx_data_ready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Last data bit, so the invert setting shows by itself
  logic bit_q_ff;
  logic inv_seen;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n)
      bit_q_ff <= 1'b0;
    else
      bit_q_ff <= tx_data_bit;
  end
  assign inv_seen = tx_mod_ff ^ bit_q_ff;

  property p_tx_crc;
    tx_rate_ff != 3'h0 |-> tx_crc_append_ff;
  endproperty
  a_tx_crc: assert property (p_tx_crc)
    else $error("tx crc off above lowest rate");
  property p_rx_crc;
    rx_rate_ff != 3'h0 |-> rx_crc_check_ff;
  endproperty
  a_rx_crc: assert property (p_rx_crc)
    else $error("rx crc off above lowest rate");
  property p_tx_rate;
    reg_wr && reg_addr == 6'h12 && !reg_wdata[6]
      |-> ##2 tx_rate_ff == $past(reg_wdata[6:4], 2);
  endproperty
  a_tx_rate: assert property (p_tx_rate)
    else $error("tx rate not taken from write");
  property p_rx_rate;
    reg_wr && reg_addr == 6'h13 && !reg_wdata[6]
      |-> ##2 rx_rate_ff == $past(reg_wdata[6:4], 2);
  endproperty
  a_rx_rate: assert property (p_rx_rate)
    else $error("rx rate not taken from write");
  property p_inv;
    !$past(reg_wr, 2) |-> $stable(inv_seen);
  endproperty
  a_inv: assert property (p_inv)
    else $error("modulation polarity moved without write");
  property p_seed_rf;
    rf_busy |=> crc_seed_ff == 2'h1;
  endproperty
  a_seed_rf: assert property (p_seed_rf)
    else $error("seed not automatic during rf");
  property p_seed_sw;
    !rf_busy |=> crc_seed_ff == $past(crc_seed_select);
  endproperty
  a_seed_sw: assert property (p_seed_sw)
    else $error("seed not from software when idle");
  property p_tx_rsv;
    reg_rd && reg_addr == 6'h12 |=> reg_rdata_ff[2:0] == 3'h0;
  endproperty
  a_tx_rsv: assert property (p_tx_rsv)
    else $error("reserved tx bits read nonzero");
  property p_abort;
    cmd_other |-> ##[1:2] !rx_active_ff;
  endproperty
  a_abort: assert property (p_abort)
    else $error("receiver still active after abort");

  c_frame: cover property (rx_frame_end);
  c_pop: cover property (rx_data_valid_ff && rx_data_ready);
  c_busy: cover property (rf_busy ##1 !rf_busy);
endmodule // ctxm_mode_cfg_properties

bind ctxm_mode_cfg ctxm_mode_cfg_properties i_ctxm_mode_cfg_properties (.*);
`default_nettype wire

// [sim/ctxm_mode_cfg_tb_top.sv]
// Self-checking bench for the mode block.
// Assumes the card model drives the receive bit port.
`timescale 1ns/1ps
`default_nettype none
module ctxm_mode_cfg_tb_top;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic cmd_receive_start = 1'b0;
  logic cmd_other = 1'b0;
  logic rf_busy = 1'b0;
  logic [1:0] crc_seed_select = 2'h0;
  logic tx_data_bit = 1'b0;
  logic [7:0] error_status_register = 8'h5b;
  logic crc_correct_flag = 1'b1;
  logic rx_data_ready = 1'b0;
  logic [7:0] reg_rdata_ff, rx_data_ff;
  logic [2:0] tx_rate_ff, rx_rate_ff, spd;
  logic [1:0] crc_seed_ff;
  logic tx_mod_ff, tx_crc_append_ff, rx_crc_check_ff, rx_data_valid_ff;
  logic rx_bit_valid, rx_bit, rx_frame_end, rx_hold_ff, rx_active_ff;
  logic [95:0] big;
  int num_errors = 0;
  int tests_run = 0;

  ctxm_mode_cfg i_ctxm_mode_cfg (.*);
  ctxm_card_model i_ctxm_card_model (.*);

  // 50 ns period
  always #25 clk_sys = ~clk_sys;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Read data is registered, so sampled one edge after the strobe
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    chk(reg_rdata_ff, e);
  endtask
  task automatic start_rx;
    @(posedge clk_sys);
    cmd_receive_start <= 1'b1;
    @(posedge clk_sys);
    cmd_receive_start <= 1'b0;
  endtask
  // Bounded wait for a byte, then one-cycle ready
  task automatic pop(input logic [7:0] e);
    int n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (rx_data_valid_ff !== 1'b1 && n < 400);
    chk({7'h0, rx_data_valid_ff}, 8'h01);
    chk(rx_data_ff, e);
    rx_data_ready <= 1'b1;
    @(posedge clk_sys);
    rx_data_ready <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog, well past the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    complete_run;
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(6'h12, 8'h00);
    rd(6'h13, 8'h00);
    rd(6'h14, 8'h00);
    // Every speed code with reserved bits set and CRC bit clear
    for (int a = 0; a < 2; a++) begin
      spd = 3'h0;
      for (int c = 0; c < 8; c++) begin
        if (c < 4)
          spd = c[2:0];
        wr(6'h12 + a[5:0], {1'b0, c[2:0], 4'hf});
        rd(6'h12 + a[5:0], {spd != 3'h0, spd, a ? 4'hc : 4'h8});
        chk({5'h0, a ? rx_rate_ff : tx_rate_ff}, {5'h0, spd});
        chk({7'h0, a ? rx_crc_check_ff : tx_crc_append_ff}, {7'h0, spd != 3'h0});
      end
      wr(6'h12 + a[5:0], 8'h00);
      rd(6'h12 + a[5:0], 8'h00);
    end
    wr(6'h12, 8'h08);
    tx_data_bit <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({7'h0, tx_mod_ff}, 8'h00);
    wr(6'h12, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk({7'h0, tx_mod_ff}, 8'h01);
    rf_busy <= 1'b1;
    crc_seed_select <= 2'h3;
    repeat (2) @(posedge clk_sys);
    chk({6'h0, crc_seed_ff}, 8'h01);
    rf_busy <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({6'h0, crc_seed_ff}, 8'h03);
    // Single frame, then the receiver goes idle
    start_rx;
    i_ctxm_card_model.send_frame(96'ha5, 8);
    pop(8'ha5);
    repeat (4) @(posedge clk_sys);
    chk({7'h0, rx_active_ff}, 8'h00);
    // A 3-bit runt is dropped and the receiver keeps waiting
    wr(6'h13, 8'h08);
    start_rx;
    i_ctxm_card_model.send_frame(96'h5, 3);
    repeat (4) @(posedge clk_sys);
    chk({7'h0, rx_active_ff}, 8'h01);
    i_ctxm_card_model.send_frame(96'h3c, 8);
    pop(8'h3c);
    // Multi-frame at 424 kBd, sink stalled until the FIFO refuses
    wr(6'h13, 8'ha4);
    start_rx;
    for (int k = 0; k < 12; k++)
      big[k*8 +: 8] = 8'(8'h11 * (k + 1));
    fork
      i_ctxm_card_model.send_frame(big, 96);
      begin
        repeat (150) @(posedge clk_sys);
        chk({7'h0, rx_hold_ff}, 8'h01);
        for (int k = 0; k < 12; k++)
          pop(big[k*8 +: 8]);
        pop(8'h5f);
      end
    join
    repeat (4) @(posedge clk_sys);
    chk({7'h0, rx_active_ff}, 8'h01);
    crc_correct_flag <= 1'b0;
    i_ctxm_card_model.send_frame(96'h77, 8);
    pop(8'h77);
    pop(8'h5b);
    cmd_other <= 1'b1;
    @(posedge clk_sys);
    cmd_other <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk({7'h0, rx_active_ff}, 8'h00);
    complete_run;
  end
endmodule // ctxm_mode_cfg_tb_top
`default_nettype wire
